// ---- two_wire_pkg.sv ----
// Constants shared by the two-wire mode sequencer files.
package two_wire_pkg;
  // ==========================================================================
  // Status codes, compared after masking with the status mask.
  localparam logic [7:0] STATUS_MASK = 8'hF8;
  localparam logic [7:0] CODE_IDLE = 8'hF8;
  localparam logic [7:0] CODE_START = 8'h08;
  localparam logic [7:0] CODE_RSTART = 8'h10;
  localparam logic [7:0] CODE_AW_ACK = 8'h18;
  localparam logic [7:0] CODE_AW_NACK = 8'h20;
  localparam logic [7:0] CODE_TXD_ACK = 8'h28;
  localparam logic [7:0] CODE_TXD_NACK = 8'h30;
  localparam logic [7:0] CODE_ARB_LOST = 8'h38;
  localparam logic [7:0] CODE_AR_ACK = 8'h40;
  localparam logic [7:0] CODE_AR_NACK = 8'h48;
  localparam logic [7:0] CODE_RXD_ACK = 8'h50;
  localparam logic [7:0] CODE_RXD_NACK = 8'h58;
  localparam logic [7:0] CODE_SW_ACK = 8'h60;
  localparam logic [7:0] CODE_SRD_ACK = 8'h80;
  localparam logic [7:0] CODE_SRD_NACK = 8'h88;
  localparam logic [7:0] CODE_SR_ACK = 8'hA8;
  localparam logic [7:0] CODE_STD_ACK = 8'hB8;
  localparam logic [7:0] CODE_STD_NACK = 8'hC0;
  // ==========================================================================
  // Field layout of the status word and of a bus packet.
  localparam int CODE_LSB = 3;
  localparam int DATA_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // ==========================================================================
  // Timing: system clock period and serial clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
endpackage

// ---- two_wire_sync.sv ----
// Two flip-flop synchroniser for one asynchronous input.
`timescale 1ns/1ns
module two_wire_sync (
  input wire logic clk_i,   // System clock.
  input wire logic reset_i, // Asynchronous reset, active high.
  input wire logic d_i,     // Asynchronous level.
  output logic q_o          // Synchronised level.
);
  logic meta_reg;

  // The first stage feeds only the second; both reset to the released level.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

// ---- two_wire_mode_sequencer.sv ----
// Two-wire byte sequencer for master and slave transmit and receive.
`timescale 1ns/1ns
module two_wire_mode_sequencer #(
  parameter int QUARTER_CYC = two_wire_pkg::QUARTER_CYC
) (
  input wire logic clk_i,           // System clock, 20 MHz.
  input wire logic reset_i,         // Asynchronous reset, active high.
  input wire logic scl_i,           // Serial clock line level.
  output logic scl_o,               // Serial clock drive level, always low.
  output logic scl_oe_o,            // Pull the serial clock low.
  input wire logic sda_i,           // Serial data line level.
  output logic sda_o,               // Serial data drive level, always low.
  output logic sda_oe_o,            // Pull the serial data low.
  input wire logic data_wr_i,       // Write strobe for the shift data register.
  input wire logic [7:0] data_i,    // Byte written to the shift data register.
  input wire logic ctrl_wr_i,       // Write strobe for the control register.
  input wire logic ctrl_clear_i,    // Written one clears the done flag.
  input wire logic ctrl_ack_i,      // Acknowledge enable.
  input wire logic ctrl_start_i,    // Start request.
  input wire logic ctrl_stop_i,     // Stop request.
  input wire logic ctrl_enable_i,   // Unit enable.
  input wire logic [1:0] prescale_i, // Prescaler bits shown in the status word.
  input wire logic [6:0] own_addr_i, // Own slave address.
  output logic [7:0] data_o,        // Shift data register contents.
  output logic [7:0] status_o,      // Status code and prescaler bits.
  output logic done_o,              // Transfer done flag.
  output logic wcol_o,              // Write collision bit.
  output logic stop_o               // Stop request bit.
);
  import two_wire_pkg::*;

  typedef enum {IDLE, M_START, M_BIT, M_STOP, M_WAIT, S_START, S_BIT, S_WAIT} state_t;
  localparam logic [15:0] QTR_LAST = 16'(QUARTER_CYC - 1);

  state_t state_reg;
  logic scl_s, sda_s, scl_p, sda_p, busy_reg;
  logic ack_en_reg, start_reg, enable_reg;
  logic [15:0] cnt_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [4:0] code_reg;
  logic done_reg, stop_reg, master_reg, tx_reg, addr_reg, dir_reg, nack_reg, acked_reg;
  logic tick, go, rise, fall, start_det, stop_det, match;

  // ==========================================================================
  // Line sampling and bus condition detection.
  two_wire_sync u_scl (.clk_i(clk_i), .reset_i(reset_i), .d_i(scl_i), .q_o(scl_s));
  two_wire_sync u_sda (.clk_i(clk_i), .reset_i(reset_i), .d_i(sda_i), .q_o(sda_s));

  // Previous synchronised levels for edge finding.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  assign rise = scl_s & ~scl_p;
  assign fall = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
  assign go = ctrl_wr_i & ctrl_clear_i & ctrl_enable_i;
  assign match = ack_en_reg & (sh_reg[7:1] == own_addr_i);
  assign tick = (cnt_reg == QTR_LAST);

  // Bus busy from any START until the next STOP.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Control bits kept from the last control write.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_en_reg <= 1'b0;
      start_reg <= 1'b0;
      enable_reg <= 1'b0;
    end else if (ctrl_wr_i) begin
      ack_en_reg <= ctrl_ack_i;
      start_reg <= ctrl_start_i;
      enable_reg <= ctrl_enable_i;
    end
  end

  // A data write without done is dropped and flagged; a good write clears it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wcol_o <= 1'b0;
    end else if (data_wr_i) begin
      wcol_o <= ~done_reg;
    end
  end

  // Status word: code in the upper bits, bit 2 zero, prescaler bits below.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_o <= {CODE_IDLE[7:3], 3'b000};
    end else begin
      status_o <= {code_reg, 1'b0, prescale_i};
    end
  end

  // Quarter-bit timer for the master's own clock.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_reg <= 16'h0000;
    end else if (tick || state_reg == IDLE || state_reg == M_WAIT) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // Main sequencer for all four roles.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= IDLE;
      q_reg <= 2'b00;
      bit_reg <= 4'h0;
      sh_reg <= DATA_RESET;
      code_reg <= CODE_IDLE[7:3];
      done_reg <= 1'b0;
      stop_reg <= 1'b0;
      master_reg <= 1'b0;
      tx_reg <= 1'b0;
      addr_reg <= 1'b0;
      dir_reg <= 1'b0;
      nack_reg <= 1'b0;
      acked_reg <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      if (ctrl_wr_i && ctrl_clear_i) begin
        done_reg <= 1'b0;
      end
      if (ctrl_wr_i) begin
        stop_reg <= ctrl_stop_i;
      end
      if (data_wr_i && done_reg) begin
        sh_reg <= data_i;
      end
      case (state_reg)
        IDLE: begin
          scl_oe_o <= 1'b0;
          sda_oe_o <= 1'b0;
          if (start_det && enable_reg) begin
            state_reg <= S_START;
            bit_reg <= 4'h0;
            addr_reg <= 1'b1;
            tx_reg <= 1'b0;
          end else if (start_reg && enable_reg && !done_reg && !busy_reg) begin
            state_reg <= M_START;
            q_reg <= 2'b00;
          end
        end
        M_START: if (tick && (q_reg != 2'd2 || scl_s)) begin
          q_reg <= q_reg + 2'd1;
          case (q_reg)
            2'd0: sda_oe_o <= 1'b0;
            2'd1: scl_oe_o <= 1'b0;
            2'd2: sda_oe_o <= 1'b1;
            default: begin
              scl_oe_o <= 1'b1;
              done_reg <= 1'b1;
              code_reg <= master_reg ? CODE_RSTART[7:3] : CODE_START[7:3];
              master_reg <= 1'b1;
              addr_reg <= 1'b1;
              tx_reg <= 1'b1;
              state_reg <= M_WAIT;
            end
          endcase
        end
        M_BIT: if (tick && (q_reg != 2'd2 || scl_s)) begin
          q_reg <= q_reg + 2'd1;
          case (q_reg)
            2'd0: if (bit_reg == ACK_SLOT) begin
              sda_oe_o <= ~tx_reg & ack_en_reg;
            end else begin
              sda_oe_o <= tx_reg & ~sh_reg[7];
            end
            2'd1: scl_oe_o <= 1'b0;
            2'd2: if (bit_reg == ACK_SLOT) begin
              nack_reg <= sda_s;
            end else begin
              sh_reg <= {sh_reg[6:0], tx_reg ? 1'b0 : sda_s};
            end
            default: begin
              scl_oe_o <= 1'b1;
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == ACK_SLOT) begin
                state_reg <= M_WAIT;
                done_reg <= 1'b1;
                addr_reg <= 1'b0;
                if (addr_reg) begin
                  tx_reg <= ~dir_reg;
                  if (dir_reg) begin
                    code_reg <= nack_reg ? CODE_AR_NACK[7:3] : CODE_AR_ACK[7:3];
                  end else begin
                    code_reg <= nack_reg ? CODE_AW_NACK[7:3] : CODE_AW_ACK[7:3];
                  end
                end else if (tx_reg) begin
                  code_reg <= nack_reg ? CODE_TXD_NACK[7:3] : CODE_TXD_ACK[7:3];
                end else begin
                  code_reg <= ack_en_reg ? CODE_RXD_ACK[7:3] : CODE_RXD_NACK[7:3];
                end
              end
            end
          endcase
        end
        M_STOP: if (tick && (q_reg != 2'd2 || scl_s)) begin
          q_reg <= q_reg + 2'd1;
          case (q_reg)
            2'd0: sda_oe_o <= 1'b1;
            2'd1: scl_oe_o <= 1'b0;
            2'd2: sda_oe_o <= 1'b0;
            default: begin
              stop_reg <= 1'b0;
              master_reg <= 1'b0;
              state_reg <= start_reg ? M_START : IDLE;
            end
          endcase
        end
        M_WAIT: if (go) begin
          q_reg <= 2'b00;
          bit_reg <= 4'h0;
          if (ctrl_stop_i) begin
            state_reg <= M_STOP;
          end else if (ctrl_start_i) begin
            state_reg <= M_START;
          end else begin
            state_reg <= M_BIT;
            dir_reg <= addr_reg ? sh_reg[0] : dir_reg;
          end
        end
        // The clock fall that closes a START is not a bit slot, so it is skipped here.
        S_START: if (stop_det) begin
          state_reg <= IDLE;
        end else if (fall) begin
          state_reg <= S_BIT;
        end
        S_WAIT: if (go) begin
          state_reg <= S_BIT;
          bit_reg <= 4'h0;
          scl_oe_o <= 1'b0;
          sda_oe_o <= tx_reg & ~sh_reg[7];
        end
        S_BIT: if (stop_det) begin
          state_reg <= IDLE;
        end else if (start_det) begin
          state_reg <= S_START;
          bit_reg <= 4'h0;
          addr_reg <= 1'b1;
          tx_reg <= 1'b0;
          sda_oe_o <= 1'b0;
        end else if (rise) begin
          if (bit_reg == ACK_SLOT) begin
            nack_reg <= sda_s;
          end else begin
            sh_reg <= {sh_reg[6:0], tx_reg ? 1'b0 : sda_s};
          end
        end else if (fall) begin
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg < ACK_SLOT - 4'h1) begin
            sda_oe_o <= tx_reg & ~sh_reg[7];
          end else if (bit_reg == ACK_SLOT - 4'h1) begin
            acked_reg <= addr_reg ? match : ack_en_reg;
            sda_oe_o <= ~tx_reg & (addr_reg ? match : ack_en_reg);
          end else begin
            sda_oe_o <= 1'b0;
            addr_reg <= 1'b0;
            if (addr_reg && !acked_reg) begin
              state_reg <= IDLE;
            end else begin
              state_reg <= S_WAIT;
              scl_oe_o <= 1'b1;
              done_reg <= 1'b1;
              if (addr_reg) begin
                tx_reg <= sh_reg[0];
                code_reg <= sh_reg[0] ? CODE_SR_ACK[7:3] : CODE_SW_ACK[7:3];
              end else if (tx_reg) begin
                code_reg <= nack_reg ? CODE_STD_NACK[7:3] : CODE_STD_ACK[7:3];
              end else begin
                code_reg <= acked_reg ? CODE_SRD_ACK[7:3] : CODE_SRD_NACK[7:3];
              end
            end
          end
        end
        default: state_reg <= IDLE;
      endcase
    end
  end

  // Open-drain drive levels are fixed low; only the enables move.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign data_o = sh_reg;
  assign done_o = done_reg;
  assign stop_o = stop_reg;

  // ==========================================================================
  // Checks.
  chk_wcol_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    data_wr_i && !done_reg |=> wcol_o && data_o == $past(data_o) || state_reg == M_BIT
      || state_reg == S_BIT) else $error("write collision not flagged");
  chk_done_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    done_reg && !(ctrl_wr_i && ctrl_clear_i) |=> done_reg) else $error("done dropped");
  chk_suspend_clock: assert property (@(posedge clk_i) disable iff (reset_i)
    done_reg && (state_reg == M_WAIT || state_reg == S_WAIT) |-> scl_oe_o)
    else $error("clock not held while done");
  chk_start_code: assert property (@(posedge clk_i) disable iff (reset_i)
    state_reg == M_START && tick && q_reg == 2'd3 && !master_reg
    |=> done_reg ##1 status_o[7:3] == CODE_START[7:3]) else $error("bad start code");
  chk_addr_write_code: assert property (@(posedge clk_i) disable iff (reset_i)
    state_reg == M_BIT && tick && q_reg == 2'd3 && bit_reg == ACK_SLOT && addr_reg
      && !dir_reg |=> code_reg == CODE_AW_ACK[7:3] || code_reg == CODE_AW_NACK[7:3])
    else $error("bad address write code");
  chk_stop_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    state_reg == M_STOP && tick && q_reg == 2'd3 |=> !stop_o && !master_reg)
    else $error("stop request not cleared");
  chk_stop_after_ack: assert property (@(posedge clk_i) disable iff (reset_i)
    state_reg == M_STOP && $past(state_reg) != M_STOP
    |-> $past(state_reg) == M_WAIT && $past(done_reg)) else $error("stop before acknowledge done");
  chk_open_drain: assert property (@(posedge clk_i) disable iff (reset_i)
    !scl_o && !sda_o) else $error("line driven high");
  chk_status_mask: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 status_o == {$past(code_reg), 1'b0, $past(prescale_i)}) else $error("status layout");
  chk_packet_len: assert property (@(posedge clk_i) disable iff (reset_i)
    bit_reg <= ACK_SLOT + 4'h1) else $error("packet longer than nine slots");
  chk_master_ack: assert property (@(posedge clk_i) disable iff (reset_i)
    state_reg == M_BIT && !tx_reg && bit_reg == ACK_SLOT && q_reg != 2'd0
    |-> sda_oe_o == ack_en_reg) else $error("receive acknowledge wrong");
endmodule

// ---- two_wire_slave_model.sv ----
// Behavioural slave device on the two-wire bus, the far side of the sequencer.
`timescale 1ns/1ns
module two_wire_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A // Own address of the model, value arbitrary.
) (
  input wire logic scl_i,           // Bus clock level.
  input wire logic sda_i,           // Bus data level.
  input wire logic nack_i,          // Refuse written data bytes.
  input wire logic [7:0] rd_byte_i, // Byte returned on reads.
  output logic sda_oe_o,            // Pull the data line low.
  output logic [7:0] last_o,        // Last byte written to the model.
  output int edges_o                // Count of clock rises.
);
  logic act = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic adr = 1'b0;
  logic slot = 1'b0;
  logic [7:0] sh = 8'h00;
  int bitn = 0;
  initial begin
    sda_oe_o = 1'b0;
    last_o = 8'h00;
    edges_o = 0;
  end
  // ==========================================================================
  // Framing: data falling while clock is high opens a frame, rising closes it.
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b1;
    adr = 1'b1;
    slot = 1'b0;
    bitn = 0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b0;
    sel = 1'b0;
    sda_oe_o = 1'b0;
  end
  // ==========================================================================
  // Bits are taken on clock rises, MSB first; a master refusal ends a read.
  always @(posedge scl_i) begin
    edges_o++;
    if (act && slot && rd && sda_i) sel = 1'b0;
    else if (act && !slot && bitn < 8) begin
      sh = {sh[6:0], sda_i};
      bitn++;
    end
  end
  // ==========================================================================
  // Data is changed only while the clock is low; released lines float high.
  always @(negedge scl_i) if (act) begin
    if (bitn == 8 && !slot) begin
      slot = 1'b1;
      if (adr) begin
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
      end else if (sel && !rd) last_o = sh;
      sda_oe_o = sel && (adr || (!rd && !nack_i));
    end else if (slot) begin
      slot = 1'b0;
      bitn = 0;
      adr = 1'b0;
      sda_oe_o = sel && rd && !rd_byte_i[7];
    end else sda_oe_o = sel && rd && !adr && !rd_byte_i[7 - bitn];
  end
endmodule

// ---- test_two_wire_mode_sequencer.sv ----
// Self-checking bench for the two-wire mode sequencer.
`timescale 1ns/1ns
module test_two_wire_mode_sequencer;
  import two_wire_pkg::*;
  localparam logic [6:0] SLV = 7'h2A;
  logic clk_i = 1'b0, reset_i = 1'b1, data_wr_i = 1'b0, ctrl_wr_i = 1'b0;
  logic ctrl_clear_i = 1'b0, ctrl_ack_i = 1'b0, ctrl_start_i = 1'b0;
  logic ctrl_stop_i = 1'b0, ctrl_enable_i = 1'b0, nack = 1'b0;
  logic tb_scl_low = 1'b0, tb_sda_low = 1'b0, done_q = 1'b0, done_q2 = 1'b0;
  logic [1:0] prescale_i = 2'h0;
  logic [6:0] own_addr_i = 7'h55;
  logic [7:0] data_i = 8'h00, rd_byte = 8'h00, b;
  logic scl_o, scl_oe_o, sda_o, sda_oe_o, done_o, wcol_o, stop_o, slv_oe;
  logic [7:0] data_o, status_o, last;
  logic [7:0] exp_q[$];
  int edges, e0, error_cnt = 0, checked = 0, cyc = 0;
  // Open-drain bus with pull-ups: any party pulling low wins.
  wire scl = !(scl_oe_o || tb_scl_low);
  wire sda = !(sda_oe_o || slv_oe || tb_sda_low);
  always #25 clk_i = !clk_i;
  two_wire_mode_sequencer #(.QUARTER_CYC(4)) i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .data_wr_i(data_wr_i), .data_i(data_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_clear_i(ctrl_clear_i), .ctrl_ack_i(ctrl_ack_i), .ctrl_start_i(ctrl_start_i),
    .ctrl_stop_i(ctrl_stop_i), .ctrl_enable_i(ctrl_enable_i), .prescale_i(prescale_i),
    .own_addr_i(own_addr_i), .data_o(data_o), .status_o(status_o), .done_o(done_o),
    .wcol_o(wcol_o), .stop_o(stop_o));
  two_wire_slave_model #(.ADDR(SLV)) i_slave (.scl_i(scl), .sda_i(sda), .nack_i(nack),
    .rd_byte_i(rd_byte), .sda_oe_o(slv_oe), .last_o(last), .edges_o(edges));
  // ==========================================================================
  // Comparison, verdict and hang guard.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // One cycle after done rises, the status word has settled; the oldest note is taken then.
  always @(negedge clk_i) begin
    if (done_q && !done_q2) begin
      if (exp_q.size() == 0) check(status_o, 8'hXX);
      else check(status_o & STATUS_MASK, exp_q.pop_front());
    end
    done_q2 = done_q;
    done_q = (done_o === 1'b1);
  end
  // ==========================================================================
  // Software side: control writes, data writes and waits for done.
  task automatic ctl(input logic c, a, s, p, e);
    @(negedge clk_i);
    {ctrl_clear_i, ctrl_ack_i, ctrl_start_i, ctrl_stop_i, ctrl_enable_i} = {c, a, s, p, e};
    ctrl_wr_i = 1'b1;
    @(negedge clk_i);
    ctrl_wr_i = 1'b0;
  endtask
  task automatic dwr(input logic [7:0] d);
    @(negedge clk_i);
    data_i = d;
    data_wr_i = 1'b1;
    @(negedge clk_i);
    data_wr_i = 1'b0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (done_o !== 1'b1 && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 1000) begin
      check(8'h00, 8'h01);
      report_and_stop();
    end
    @(negedge clk_i);
  endtask
  task automatic step(input logic [7:0] d, input logic [7:0] st, input logic a, s);
    if (!s) dwr(d);
    exp_q.push_back(st);
    ctl(1'b1, a, s, 1'b0, 1'b1);
    wait_done();
  endtask
  task automatic stop_bus;
    int n;
    ctl(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    check(stop_o, 8'h01);
    n = 0;
    while (stop_o !== 1'b0 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    repeat (4) @(negedge clk_i);
    check({stop_o, done_o, scl, sda}, 8'h03);
  endtask
  task automatic tend(input string name);
    $display("test %s finished, mismatches so far %0d", name, error_cnt);
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(32'hF8ACD6B4));
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    @(negedge clk_i);
    check({3'h0, done_o, wcol_o, stop_o, scl_oe_o, sda_oe_o}, 8'h00);
    check(status_o, CODE_IDLE);
    prescale_i = 2'($urandom());
    own_addr_i = 7'($urandom()) ^ 7'h40;
    if (own_addr_i == SLV) own_addr_i = 7'h11;
    repeat (2) @(negedge clk_i);
    check(status_o, CODE_IDLE | {6'h00, prescale_i});
    tend("reset");
    dwr(8'($urandom()));
    @(negedge clk_i);
    check({wcol_o, data_o}, {1'b1, DATA_RESET});
    tend("collision");
    step(8'h00, CODE_START, 1'b0, 1'b1);
    step({SLV, 1'b0}, CODE_AW_ACK, 1'b0, 1'b0);
    check(wcol_o, 8'h00);
    e0 = edges;
    repeat (60) @(negedge clk_i);
    check(edges - e0, 8'h00);
    b = 8'($urandom());
    step(b, CODE_TXD_ACK, 1'b0, 1'b0);
    check(last, b);
    nack = 1'b1;
    step(~b, CODE_TXD_NACK, 1'b0, 1'b0);
    nack = 1'b0;
    stop_bus();
    tend("master write");
    step(8'h00, CODE_START, 1'b0, 1'b1);
    step({SLV ^ 7'h01, 1'b0}, CODE_AW_NACK, 1'b0, 1'b0);
    stop_bus();
    tend("address refused");
    rd_byte = 8'($urandom());
    step(8'h00, CODE_START, 1'b0, 1'b1);
    step({SLV, 1'b1}, CODE_AR_ACK, 1'b0, 1'b0);
    step(8'h00, CODE_RXD_NACK, 1'b0, 1'b0);
    check(data_o, rd_byte);
    stop_bus();
    tend("master read");
    // Bench acts as another master with a 400 ns link clock.
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    exp_q.push_back(CODE_SW_ACK);
    b = {own_addr_i, 1'b0};
    tb_sda_low = 1'b1;
    #200 tb_scl_low = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      tb_sda_low = !b[i];
      #200 tb_scl_low = 1'b0;
      #200 tb_scl_low = 1'b1;
    end
    tb_sda_low = 1'b0;
    #200 tb_scl_low = 1'b0;
    #100 check(sda, 8'h00);
    #100 tb_scl_low = 1'b1;
    #200 tb_scl_low = 1'b0;
    wait_done();
    check({scl, scl_oe_o}, 8'h01);
    ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    tb_scl_low = 1'b1;
    tb_sda_low = 1'b1;
    #200 tb_scl_low = 1'b0;
    #200 tb_sda_low = 1'b0;
    repeat (8) @(negedge clk_i);
    check({done_o, scl, sda}, 8'h03);
    check(exp_q.size(), 8'h00);
    tend("slave receive");
    report_and_stop();
  end
endmodule
